// >>> pkg/frt_timer_pkg.sv
// Constants shared by the timer and capture block
package frt_timer_pkg;

   // ==========================================================
   // Timing
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned US_NS = 1000;
   localparam int unsigned US_DIV_CYCLES = US_NS / CLK_PERIOD_NS;
   localparam int unsigned TICK_PERIOD_US = 1024;
   localparam int unsigned TICK_BITS = $clog2(TICK_PERIOD_US);

   // ==========================================================
   // Widths
   localparam int unsigned FREE_W = 16;
   localparam int unsigned PIT_W = 12;
   localparam int unsigned CAP_W = 8;
   localparam int unsigned NUM_CAP = 2;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned NUM_EVT = 5;

   // ==========================================================
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_FREE_COUNT = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_PIT_RELOAD = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_PIT_COUNT = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_MASK = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_CAP_A_RISE = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_CAP_A_FALL = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_CAP_B_RISE = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_CAP_B_FALL = 8'h24;

   // ==========================================================
   // Control field positions
   localparam int unsigned CTRL_PIT_EN = 0;
   localparam int unsigned CTRL_GANG = 1;
   localparam int unsigned CTRL_SHIFT_LO = 4;
   localparam int unsigned CTRL_SHIFT_W = 4;
   localparam int unsigned CTRL_EDGE_LO = 8;
   localparam int unsigned CTRL_W = 12;

   // ==========================================================
   // Status bit positions
   localparam int unsigned EVT_TICK = 0;
   localparam int unsigned EVT_WRAP = 1;
   localparam int unsigned EVT_PIT = 2;
   localparam int unsigned EVT_CAP_A = 3;
   localparam int unsigned EVT_CAP_B = 4;

   // ==========================================================
   // Reset values and bus answers
   localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;
   localparam logic [PIT_W-1:0] PIT_RELOAD_RESET = 12'h3E7;
   localparam logic [NUM_EVT-1:0] MASK_RESET = 5'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : frt_timer_pkg

// >>> sim/free_running_timer_capture_bench.sv
// Self-checking bench for the timer and capture block over AXI4-Lite
`timescale 1ns/100ps

module free_running_timer_capture_bench
   import frt_timer_pkg::*;
;
   localparam int US = 1;
   localparam int LIMIT = 100000;

   // ==========================================================
   // Signals
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, capture_pin_a, capture_pin_b, tick_out, pit_d;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rsp;
   logic [NUM_EVT-1:0] irq_lines;
   logic [15:0] f0, f1, lo;
   int mismatches, n_checks, cyc, n;
   int pit_rise[$];

   free_running_timer_capture #(.US_DIV(US)) dut (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .capture_pin_a(capture_pin_a),
      .capture_pin_b(capture_pin_b), .tick_out(tick_out), .irq_lines(irq_lines));

   // ==========================================================
   // Clock, cycle count, interval timer edge log and timeout
   initial
   begin
      aclk = 0;
      forever #2.5 aclk = ~aclk;
   end

   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      pit_d <= irq_lines[EVT_PIT];
      if (irq_lines[EVT_PIT] === 1'b1 && pit_d === 1'b0)
         pit_rise.push_back(cyc);
      if (cyc == LIMIT)
      begin
         mismatches++;
         final_report();
      end
   end

   // ==========================================================
   // Checking and bus tasks
   task final_report();
      if (mismatches == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report

   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_ok, w_ok;
      aw_ok = 0;
      w_ok = 0;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1;
      wdata <= d;
      wvalid <= 1;
      bready <= 1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge aclk);
         if (awvalid === 1'b1 && awready === 1'b1)
         begin
            aw_ok = 1;
            awvalid <= 0;
         end
         if (wvalid === 1'b1 && wready === 1'b1)
         begin
            w_ok = 1;
            wvalid <= 0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      check("bresp", 32'(bresp), 32'(er));
      bready <= 0;
   endtask : axi_write

   task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 0;
      while (rvalid !== 1'b1)
         @(posedge aclk);
      d = rdata;
      r = rresp;
      rready <= 0;
   endtask : axi_read

   task rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input string nm);
      axi_read(a, rd, rsp);
      check(nm, rd, e);
      check("rresp", 32'(rsp), 32'(er));
   endtask : rchk

   // Reads the counter around a pin change so the capture has a known window
   task pin_edge(input logic on_b, input logic lvl);
      axi_read(OFS_FREE_COUNT, rd, rsp);
      f0 = rd[15:0];
      @(posedge aclk);
      if (on_b)
         capture_pin_b <= lvl;
      else
         capture_pin_a <= lvl;
      repeat (3) @(posedge aclk);
      axi_read(OFS_FREE_COUNT, rd, rsp);
      f1 = rd[15:0];
   endtask : pin_edge

   task wait_pit(input int k);
      n = 0;
      while (pit_rise.size() < k && n < 500)
      begin
         @(posedge aclk);
         n++;
      end
   endtask : wait_pit

   function automatic logic in8(logic [7:0] v, logic [7:0] l, logic [7:0] h);
      return 8'(v - l) <= 8'(h - l);
   endfunction : in8

   function automatic logic in16(logic [15:0] v, logic [15:0] l, logic [15:0] h);
      return 16'(v - l) <= 16'(h - l);
   endfunction : in16

   // ==========================================================
   // Main sequence
   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready, capture_pin_a, capture_pin_b} = '0;
      {awaddr, araddr, wdata, mismatches, n_checks} = '0;
      wstrb = 4'hF;
      aresetn = 0;
      repeat (16) @(posedge aclk);
      aresetn <= 1;
      // Reset values and bus errors
      rchk(OFS_CTRL, 32'(CTRL_RESET), RESP_OKAY, "ctrl");
      rchk(OFS_PIT_RELOAD, 32'(PIT_RELOAD_RESET), RESP_OKAY, "reload");
      rchk(OFS_PIT_COUNT, 32'(PIT_RELOAD_RESET), RESP_OKAY, "pit_count");
      rchk(OFS_MASK, 32'(MASK_RESET), RESP_OKAY, "mask");
      rchk(OFS_STATUS, 32'h0000_0000, RESP_OKAY, "status");
      for (int i = 0; i < 4; i++)
         rchk(OFS_CAP_A_RISE + 8'(4 * i), 32'h0000_0000, RESP_OKAY, "cap_reset");
      rchk(8'h28, 32'h0000_0000, RESP_SLVERR, "unmapped");
      axi_write(OFS_FREE_COUNT, 32'h0000_1234, RESP_SLVERR);
      axi_write(8'h40, 32'h0000_1234, RESP_SLVERR);
      // Counter advances once per microsecond
      axi_read(OFS_FREE_COUNT, rd, rsp);
      f0 = rd[15:0];
      repeat (20) @(posedge aclk);
      axi_read(OFS_FREE_COUNT, rd, rsp);
      check("advance", 32'(16'(rd[15:0] - f0) >= 16'd20 && 16'(rd[15:0] - f0) <= 16'd40), 1);
      // Tick period, masking and clearing
      for (int k = 0; k < 2; k++)
      begin
         n = 0;
         do
         begin
            @(posedge aclk);
            n++;
         end while (tick_out !== 1'b1 && n < 5000);
      end
      check("tick_period", n, 1024 * US);
      rchk(OFS_STATUS, 32'h0000_0001, RESP_OKAY, "status_tick");
      check("irq_masked", 32'(irq_lines), 0);
      axi_write(OFS_MASK, 32'h0000_001F, RESP_OKAY);
      repeat (2) @(posedge aclk);
      check("irq_tick", 32'(irq_lines[EVT_TICK]), 1);
      axi_write(OFS_STATUS, 32'h0000_0001, RESP_OKAY);
      rchk(OFS_STATUS, 32'h0000_0000, RESP_OKAY, "status_clear");
      // Interval timer
      axi_write(OFS_PIT_RELOAD, 32'h0000_0014, RESP_OKAY);
      axi_write(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
      wait_pit(1);
      axi_write(OFS_STATUS, 32'h0000_0004, RESP_OKAY);
      wait_pit(2);
      check("pit_count_rises", pit_rise.size(), 2);
      check("pit_interval", pit_rise[1] - pit_rise[0], 21 * US);
      axi_write(OFS_CTRL, 32'h0000_0F00, RESP_OKAY);
      axi_write(OFS_STATUS, 32'h0000_001F, RESP_OKAY);
      // Pin A rising edge, low byte
      pin_edge(0, 1);
      axi_read(OFS_CAP_A_RISE, rd, rsp);
      lo = rd[15:0];
      check("cap_a_rise", 32'(in8(rd[7:0], f0[7:0], f1[7:0])), 1);
      rchk(OFS_CAP_A_FALL, 32'h0000_0000, RESP_OKAY, "cap_a_fall_idle");
      axi_read(OFS_STATUS, rd, rsp);
      check("status_cap", 32'(rd[EVT_CAP_B:EVT_CAP_A]), 32'h0000_0001);
      check("irq_cap_a", 32'(irq_lines[EVT_CAP_A]), 1);
      // Pin A falling edge, high byte
      axi_write(OFS_CTRL, 32'h0000_0F80, RESP_OKAY);
      pin_edge(0, 0);
      axi_read(OFS_CAP_A_FALL, rd, rsp);
      check("cap_a_fall", 32'(in8(rd[7:0], f0[15:8], f1[15:8])), 1);
      rchk(OFS_CAP_A_RISE, 32'(lo), RESP_OKAY, "cap_a_hold");
      rchk(OFS_CAP_A_RISE, 32'(lo), RESP_OKAY, "cap_a_reread");
      // Pin B rising edge, middle slice
      axi_write(OFS_CTRL, 32'h0000_0F40, RESP_OKAY);
      pin_edge(1, 1);
      axi_read(OFS_CAP_B_RISE, rd, rsp);
      check("cap_b_rise", 32'(in8(rd[7:0], f0[11:4], f1[11:4])), 1);
      axi_read(OFS_STATUS, rd, rsp);
      check("status_cap_b", 32'(rd[EVT_CAP_B]), 1);
      // Disabled edge on pin B is ignored
      axi_write(OFS_CTRL, 32'h0000_0300, RESP_OKAY);
      axi_write(OFS_STATUS, 32'h0000_001F, RESP_OKAY);
      pin_edge(1, 0);
      rchk(OFS_CAP_B_FALL, 32'h0000_0000, RESP_OKAY, "cap_b_off");
      axi_read(OFS_STATUS, rd, rsp);
      check("status_b_off", 32'(rd[EVT_CAP_B]), 0);
      // Ganged 16-bit capture on pin A
      axi_write(OFS_CTRL, 32'h0000_0302, RESP_OKAY);
      pin_edge(0, 1);
      axi_read(OFS_CAP_A_RISE, rd, rsp);
      lo = rd[15:0];
      axi_read(OFS_CAP_B_RISE, rd, rsp);
      check("gang", 32'(in16({rd[7:0], lo[7:0]}, f0, f1)), 1);
      // Counter wrap
      n = 0;
      while (irq_lines[EVT_WRAP] !== 1'b1 && n < 70000)
      begin
         @(posedge aclk);
         n++;
      end
      check("irq_wrap", 32'(irq_lines[EVT_WRAP]), 1);
      axi_read(OFS_FREE_COUNT, rd, rsp);
      check("after_wrap", 32'(rd[15:0] < 16'h0040), 1);
      final_report();
   end

endmodule : free_running_timer_capture_bench

// >>> verilog/capture_channel.sv
// One capture channel: edge detection and rising/falling capture registers
`timescale 1ns/100ps

module capture_channel
   import frt_timer_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Pin and configuration
   input wire logic pin,
   input wire logic en_rise,
   input wire logic en_fall,
   input wire logic [CAP_W-1:0] value,
   // Results
   output logic [CAP_W-1:0] cap_rise,
   output logic [CAP_W-1:0] cap_fall,
   output logic ev_rise,
   output logic ev_fall
);

   logic pin_prev;

   // ==========================================================
   // Edge detection
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pin_prev <= 1'b0;
      else
         pin_prev <= pin;
   end

   assign ev_rise = en_rise && pin && !pin_prev;
   assign ev_fall = en_fall && !pin && pin_prev;

   // ==========================================================
   // Separate rising and falling capture, held until the next edge
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cap_rise <= '0;
         cap_fall <= '0;
      end
      else
      begin
         if (ev_rise)
            cap_rise <= value;
         if (ev_fall)
            cap_fall <= value;
      end
   end

endmodule : capture_channel

// >>> verilog/free_running_timer_capture.sv
// Free-running timer, interval timer and capture channels behind AXI4-Lite
`timescale 1ns/100ps

module free_running_timer_capture
   import frt_timer_pkg::*;
#(
   parameter int unsigned US_DIV = US_DIV_CYCLES
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // AXI4-Lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Capture pins
   input wire logic capture_pin_a,
   input wire logic capture_pin_b,
   // Event outputs
   output logic tick_out,
   output logic [NUM_EVT-1:0] irq_lines
);

   // ==========================================================
   // Helpers
   function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            res[8*i +: 8] = new_v[8*i +: 8];
      return res;
   endfunction : merge_strb

   function automatic logic [CAP_W-1:0] slice_of(input logic [FREE_W-1:0] cnt,
                                                 input logic [CTRL_SHIFT_W-1:0] sh);
      logic [FREE_W-1:0] shifted;
      shifted = cnt >> sh;
      return shifted[CAP_W-1:0];
   endfunction : slice_of

   // ==========================================================
   // Declarations
   logic [15:0] us_cnt;
   logic us_pulse;
   logic [FREE_W-1:0] free_count;
   logic [PIT_W-1:0] pit_count;
   logic [PIT_W-1:0] pit_reload;
   logic [CTRL_W-1:0] ctrl;
   logic [NUM_EVT-1:0] status;
   logic [NUM_EVT-1:0] mask;
   logic [NUM_EVT-1:0] events;
   logic [NUM_EVT-1:0] w1c;
   logic tick_evt;
   logic wrap_evt;
   logic pit_evt;
   logic gang;
   logic [CTRL_SHIFT_W-1:0] shift;
   logic [NUM_CAP-1:0] ch_pin;
   logic [NUM_CAP-1:0] ch_en_rise;
   logic [NUM_CAP-1:0] ch_en_fall;
   logic [NUM_CAP-1:0] ev_rise;
   logic [NUM_CAP-1:0] ev_fall;
   logic [CAP_W-1:0] ch_value [NUM_CAP];
   logic [CAP_W-1:0] cap_rise [NUM_CAP];
   logic [CAP_W-1:0] cap_fall [NUM_CAP];
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic do_write;
   logic [31:0] next_rdata;
   logic next_rerr;

   // ==========================================================
   // Microsecond prescaler and free-running counter
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         us_cnt <= '0;
      else if (us_pulse)
         us_cnt <= '0;
      else
         us_cnt <= us_cnt + 16'h0001;
   end

   assign us_pulse = (us_cnt == 16'(US_DIV - 1));

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         free_count <= '0;
      else if (us_pulse)
         free_count <= free_count + 16'h0001;
   end

   assign tick_evt = us_pulse && (free_count[TICK_BITS-1:0] == '1);
   assign wrap_evt = us_pulse && (free_count == '1);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         tick_out <= 1'b0;
      else
         tick_out <= tick_evt;
   end

   // ==========================================================
   // Programmable interval timer, period of reload plus one microseconds
   assign pit_evt = us_pulse && ctrl[CTRL_PIT_EN] && (pit_count == '0);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pit_count <= PIT_RELOAD_RESET;
      else if (!ctrl[CTRL_PIT_EN])
         pit_count <= pit_reload;
      else if (pit_evt)
         pit_count <= pit_reload;
      else if (us_pulse)
         pit_count <= pit_count - 12'h001;
   end

   // ==========================================================
   // Capture channels
   assign gang = ctrl[CTRL_GANG];
   assign shift = ctrl[CTRL_SHIFT_LO +: CTRL_SHIFT_W];
   assign ch_pin[0] = capture_pin_a;
   assign ch_pin[1] = gang ? capture_pin_a : capture_pin_b;

   generate
      for (genvar c = 0; c < NUM_CAP; c++)
      begin : g_cap
         localparam int unsigned SRC = (c == 0) ? 0 : 1;
         assign ch_en_rise[c] = ctrl[CTRL_EDGE_LO + 2*(gang ? 0 : SRC)];
         assign ch_en_fall[c] = ctrl[CTRL_EDGE_LO + 2*(gang ? 0 : SRC) + 1];
         assign ch_value[c] = gang ? free_count[CAP_W*c +: CAP_W]
                                   : slice_of(free_count, shift);
         capture_channel u_chan
         (
            .aclk(aclk),
            .aresetn(aresetn),
            .pin(ch_pin[c]),
            .en_rise(ch_en_rise[c]),
            .en_fall(ch_en_fall[c]),
            .value(ch_value[c]),
            .cap_rise(cap_rise[c]),
            .cap_fall(cap_fall[c]),
            .ev_rise(ev_rise[c]),
            .ev_fall(ev_fall[c])
         );
      end
   endgenerate

   // ==========================================================
   // Sticky status, write one to clear, set wins over clear
   assign events[EVT_TICK] = tick_evt;
   assign events[EVT_WRAP] = wrap_evt;
   assign events[EVT_PIT] = pit_evt;
   assign events[EVT_CAP_A] = ev_rise[0] || ev_fall[0];
   assign events[EVT_CAP_B] = !gang && (ev_rise[1] || ev_fall[1]);
   assign w1c = (do_write && aw_addr_q == OFS_STATUS && w_strb_q[0])
                ? w_data_q[NUM_EVT-1:0] : '0;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         status <= '0;
      else
         status <= (status & ~w1c) | events;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_lines <= '0;
      else
         irq_lines <= status & mask;
   end

   // ==========================================================
   // Software-written registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl <= CTRL_RESET;
         pit_reload <= PIT_RELOAD_RESET;
         mask <= MASK_RESET;
      end
      else if (do_write)
      begin
         case (aw_addr_q)
            OFS_CTRL:
               ctrl <= CTRL_W'(merge_strb(32'(ctrl), w_data_q, w_strb_q));
            OFS_PIT_RELOAD:
               pit_reload <= PIT_W'(merge_strb(32'(pit_reload), w_data_q, w_strb_q));
            OFS_MASK:
               mask <= NUM_EVT'(merge_strb(32'(mask), w_data_q, w_strb_q));
            default:
               ;
         endcase
      end
   end

   // ==========================================================
   // AXI4-Lite write channels
   assign do_write = aw_held && w_held && !bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         awready <= 1'b0;
         aw_addr_q <= '0;
      end
      else if (awvalid && awready)
      begin
         aw_held <= 1'b1;
         awready <= 1'b0;
         aw_addr_q <= awaddr;
      end
      else
      begin
         if (do_write)
            aw_held <= 1'b0;
         awready <= !aw_held && !bvalid;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held <= 1'b0;
         wready <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end
      else if (wvalid && wready)
      begin
         w_held <= 1'b1;
         wready <= 1'b0;
         w_data_q <= wdata;
         w_strb_q <= wstrb;
      end
      else
      begin
         if (do_write)
            w_held <= 1'b0;
         wready <= !w_held && !bvalid;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid <= 1'b1;
         bresp <= (aw_addr_q == OFS_CTRL || aw_addr_q == OFS_PIT_RELOAD ||
                   aw_addr_q == OFS_STATUS || aw_addr_q == OFS_MASK)
                  ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
         bvalid <= 1'b0;
   end

   // ==========================================================
   // AXI4-Lite read channel, reads have no side effect
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      next_rerr = 1'b0;
      case (araddr)
         OFS_CTRL: next_rdata = 32'(ctrl);
         OFS_FREE_COUNT: next_rdata = 32'(free_count);
         OFS_PIT_RELOAD: next_rdata = 32'(pit_reload);
         OFS_PIT_COUNT: next_rdata = 32'(pit_count);
         OFS_STATUS: next_rdata = 32'(status);
         OFS_MASK: next_rdata = 32'(mask);
         OFS_CAP_A_RISE: next_rdata = 32'(cap_rise[0]);
         OFS_CAP_A_FALL: next_rdata = 32'(cap_fall[0]);
         OFS_CAP_B_RISE: next_rdata = 32'(cap_rise[1]);
         OFS_CAP_B_FALL: next_rdata = 32'(cap_fall[1]);
         default: next_rerr = 1'b1;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= next_rdata;
         rresp <= next_rerr ? RESP_SLVERR : RESP_OKAY;
      end
      else
      begin
         if (rvalid && rready)
            rvalid <= 1'b0;
         arready <= !rvalid;
      end
   end

   // ==========================================================
   // Checks
   a_free_advance: assert property (@(posedge aclk) disable iff (!aresetn)
      us_pulse |=> free_count == $past(free_count) + 16'h0001)
      else $error("free counter did not advance");
   a_tick_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      tick_evt |=> status[EVT_TICK] && tick_out && free_count[TICK_BITS-1:0] == '0)
      else $error("tick not flagged at 1024 us boundary");
   a_wrap_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      (us_pulse && free_count == 16'hFFFF) |=> free_count == '0 && status[EVT_WRAP])
      else $error("wrap not flagged");
   a_pit_expire: assert property (@(posedge aclk) disable iff (!aresetn)
      pit_evt |=> status[EVT_PIT] && pit_count == $past(pit_reload))
      else $error("interval expiry mishandled");
   a_cap_slice: assert property (@(posedge aclk) disable iff (!aresetn)
      (ev_rise[0] && !gang) |=> cap_rise[0] == slice_of($past(free_count), $past(shift)))
      else $error("capture slice wrong");
   a_fall_separate: assert property (@(posedge aclk) disable iff (!aresetn)
      (ev_fall[0] && !ev_rise[0]) |=> $stable(cap_rise[0]))
      else $error("falling edge disturbed rising capture");
   a_gang_full: assert property (@(posedge aclk) disable iff (!aresetn)
      (gang && ev_rise[0]) |=> {cap_rise[1], cap_rise[0]} == $past(free_count))
      else $error("ganged capture wrong");
   a_cap_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      (ev_rise[0] || ev_fall[0]) |=> status[EVT_CAP_A] ##1 irq_lines[EVT_CAP_A] == mask[EVT_CAP_A])
      else $error("capture flag missing");
   a_cap_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      !ev_rise[1] |=> $stable(cap_rise[1]))
      else $error("capture changed without edge");
   c_gang_capture: cover property (@(posedge aclk) disable iff (!aresetn) gang && ev_rise[0]);
   c_pit_expiry: cover property (@(posedge aclk) disable iff (!aresetn) pit_evt);
   c_fall_b: cover property (@(posedge aclk) disable iff (!aresetn) ev_fall[1] && !gang);
   c_clear_race: cover property (@(posedge aclk) disable iff (!aresetn) (|(w1c & events)));

endmodule : free_running_timer_capture
